// *** logic/temp_sensor_serial_regs.svh ***
// register layout constants of the serial temperature sensor
`ifndef TEMP_SENSOR_SERIAL_REGS_SVH
`define TEMP_SENSOR_SERIAL_REGS_SVH

// mode control word
`define MODE_RESET      16'h0000
`define MODE_SEL_MSB    7
`define MODE_SEL_LSB    0
`define MODE_SHUT_CODE  8'hff

// temperature result layout
`define TEMP_VAL_MSB    15
`define TEMP_VAL_LSB    3
`define TEMP_FIRST_BIT  2
`define TEMP_RESET      13'h1fe0
`define TEMP_STEP_DIV   16

// maker identity layout
`define ID_CODE_MSB     15
`define ID_CODE_LSB     8
`define ID_LOW_ZERO     8'h00

// serial slot timing, in link clocks
`define DRIVEN_BITS     4'he
`define SLOT_LAST       4'hf

`endif

// *** logic/temp_sensor_serial_pkg.sv ***
// types shared by the serial temperature sensor modules
package temp_sensor_serial_pkg;
`include "temp_sensor_serial_regs.svh"

	// operating mode, one bit apart
	typedef enum logic {
		MODE_CONT = 1'b0,
		MODE_SHUT = 1'b1
	} sensMode_t;

	// system clock state
	typedef struct packed {
		logic [15:0] modeWord;
		sensMode_t   mode;
		logic [12:0] tempValue;
		logic        firstDone;
		logic [15:0] snapshot;
		logic        tglSeen;
		logic        armed;
	} sysState_t;

	// link state cleared by every frame start
	typedef struct packed {
		logic [3:0]  bitPos;
		logic        oddSlot;
		logic        shutSel;
		logic [15:0] shiftIn;
	} linkFrame_t;

	// link state that outlives a frame
	typedef struct packed {
		logic [15:0] wordOut;
		logic        wrTgl;
	} linkHeld_t;

	// falling edge output stage
	typedef struct packed {
		logic [3:0] outPos;
		logic       outOdd;
	} linkOut_t;

	// pin synchroniser
	typedef struct packed {
		logic [2:0] stages;
		logic       level;
	} syncState_t;
endpackage

// *** logic/pin_sync.sv ***
// three-stage synchroniser with agreement filter
`timescale 1ns/10ps
module pin_sync #(
	parameter logic RESET_LEVEL = 1'b0
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic reset,
	// foreign level in, filtered level out
	input  wire logic pinIn,
	output wire logic levelOut
);
	import temp_sensor_serial_pkg::*;

	syncState_t st_reg;   // stages and filtered level
	syncState_t st_next;  // next value

	// stage one feeds only stage two; the filter sees two and three
	always_comb begin
		st_next        = st_reg;
		st_next.stages = {st_reg.stages[1:0], pinIn};
		if (st_reg.stages[1] == st_reg.stages[2]) begin
			st_next.level = st_reg.stages[2];
		end
	end

	// synchronous reset to the idle level
	always_ff @(posedge clk) begin
		if (reset) begin
			st_reg <= '{stages: {3{RESET_LEVEL}}, level: RESET_LEVEL};
		end else begin
			st_reg <= st_next;
		end
	end

	assign levelOut = st_reg.level;
endmodule // pin_sync

// *** logic/link_shifter.sv ***
// serial link end, clocked by the master's serial clock
`timescale 1ns/10ps
`include "temp_sensor_serial_regs.svh"
module link_shifter #(
	parameter logic [7:0] MAKER_CODE = 8'h3c  // arbitrary value
) (
	// link clock and frame select
	input  wire logic        sck,
	input  wire logic        csN,
	// data pin, split
	input  wire logic        sioIn,
	output wire logic        sioOut,
	output wire logic        sioOe_n,
	// words to and from the system side
	input  wire logic [15:0] readWord,
	output wire logic [15:0] modeWord,
	output wire logic        modeTgl
);
	import temp_sensor_serial_pkg::*;

	linkFrame_t  fr_reg;        // frame counters
	linkFrame_t  fr_next;
	linkHeld_t   hd_reg = '0;   // held word and toggle
	linkHeld_t   hd_next;
	linkOut_t    ou_reg;        // output position
	linkOut_t    ou_next;
	logic [15:0] inWord;        // shift-in with current bit
	logic [15:0] outWord;       // word of the read slot

	// rising edge: count bits, collect the mode word msb first
	always_comb begin
		fr_next        = fr_reg;
		hd_next        = hd_reg;
		inWord         = {fr_reg.shiftIn[14:0], sioIn};
		fr_next.bitPos = fr_reg.bitPos + 4'h1;
		if (fr_reg.oddSlot) begin
			fr_next.shiftIn = inWord;
		end
		if (fr_reg.bitPos == `SLOT_LAST) begin
			fr_next.oddSlot = !fr_reg.oddSlot;
			if (fr_reg.oddSlot) begin
				// word and toggle move together; the word then rests 32 clocks
				hd_next.wordOut = inWord;
				hd_next.wrTgl   = !hd_reg.wrTgl;
				fr_next.shutSel = (inWord[`MODE_SEL_MSB:`MODE_SEL_LSB] == `MODE_SHUT_CODE);
			end
		end
	end

	// chip select high holds the frame logic, so stray clocks do nothing
	always_ff @(posedge sck or posedge csN) begin
		if (csN) begin
			fr_reg <= '0;
		end else begin
			fr_reg <= fr_next;
		end
	end

	// held state is not cleared by the frame
	always_ff @(posedge sck) begin
		hd_reg <= hd_next;
	end

	// falling edge output stage: next bit after each rising sample
	always_comb begin
		ou_next.outPos = fr_reg.bitPos;
		ou_next.outOdd = fr_reg.oddSlot;
	end

	always_ff @(negedge sck or posedge csN) begin
		if (csN) begin
			ou_reg <= '0;
		end else begin
			ou_reg <= ou_next;
		end
	end

	// identity only after a shutdown write in this frame
	assign outWord = fr_reg.shutSel ? {MAKER_CODE, `ID_LOW_ZERO} : readWord;
	// drive 14 bits of a read slot; float the tail and write slots
	assign sioOe_n = csN | ou_reg.outOdd | (ou_reg.outPos >= `DRIVEN_BITS);
	assign sioOut  = outWord[4'hf - ou_reg.outPos];
	assign modeWord = hd_reg.wordOut;
	assign modeTgl  = hd_reg.wrTgl;

	AST_TAIL_FLOAT: assert property (@(negedge sck) disable iff (csN)
		(!ou_reg.outOdd && ou_reg.outPos >= `DRIVEN_BITS) |-> sioOe_n)
		else $error("data pin driven in tail bits");

	AST_WRITE_FLOAT: assert property (@(negedge sck) disable iff (csN)
		ou_reg.outOdd |-> sioOe_n)
		else $error("data pin driven in write slot");

	AST_ID_AFTER_SHUT: assert property (@(posedge sck) disable iff (csN)
		(fr_reg.oddSlot && fr_reg.bitPos == `SLOT_LAST && inWord[7:0] == `MODE_SHUT_CODE)
		|=> fr_reg.shutSel && !fr_reg.oddSlot && fr_reg.bitPos == 4'h0)
		else $error("identity not selected after shutdown write");
endmodule // link_shifter

// *** logic/temp_sensor_serial_regs.sv ***
// serial temperature sensor register block, system clock side
//
// Overview of operation
// - three registers: result, identity, mode control
// - result and identity read only; mode write only
// - reset gives continuous mode, mode byte zero
// - low mode byte all ones enters shutdown
// - any zero in low byte means continuous
// - serial port keeps working during shutdown
// - result bits one and zero stay undriven
// - bit two set after first conversion
// - thirteen-bit result in bits fifteen to three
// - identity readable only after a shutdown write in the same frame
// - identity: code high, zeros, two undriven
// - clock ignored while select high; select frames
// - first bit on select, then falling edges
// - second sixteen clocks carry the mode word
// - one result step is a sixteenth degree
//
`timescale 1ns/10ps
`include "temp_sensor_serial_regs.svh"
module temp_sensor_serial_regs #(
	parameter logic [7:0] MAKER_CODE = 8'h3c  // arbitrary value
) (
	// system clock and reset
	input  wire logic                              sys_clk,
	input  wire logic                              reset,
	// serial link pins
	input  wire logic                              sck,
	input  wire logic                              csN,
	input  wire logic                              sioIn,
	output wire logic                              sioOut,
	output wire logic                              sioOe_n,
	// converter side
	input  wire logic [12:0]                       convData,
	input  wire logic                              convDone,
	output wire logic                              convRun,
	// mode status
	output temp_sensor_serial_pkg::sensMode_t      sensMode
);
	import temp_sensor_serial_pkg::*;

	// registered state of the system side
	sysState_t   st_reg;

	// next state
	sysState_t   st_next;

	// mode word handed over by the link
	logic [15:0] linkWord;

	// toggle marking each new mode word
	logic        linkTgl;

	// toggle after three flops
	logic        tglSync;

	// select after three flops, high while idle
	logic        csSync;

	// a frame is under way on the link
	logic        frameBusy;

	// low mode byte is the shutdown code
	logic        shutCode;

	// the mode word just arrived
	logic        modeLoad;

	// crossing plan: the link hands over one word and one toggle; only the
	// toggle passes the three flops, and the word is read straight from the
	// link side once the toggle change is seen
	// this is safe because a word rests for at least thirty-two serial clocks,
	// far longer than the toggle takes to cross; faster writes would tear it
	// the select level crosses too and freezes the read word, but it lags the
	// pin by three to four system clocks, so frames must be spaced at least
	// four system clocks apart or the first bits may come from a torn word

	// state after reset
	localparam sysState_t RESET_ST = '{
		modeWord:  `MODE_RESET,
		mode:      MODE_CONT,
		tempValue: `TEMP_RESET,
		firstDone: 1'b0,
		snapshot:  {`TEMP_RESET, 1'b0, 2'b00},
		tglSeen:   1'b0,
		armed:     1'b0
	};

	// the link end runs on the serial clock
	link_shifter #(
		.MAKER_CODE (MAKER_CODE)
	) u_link (
		.sck      (sck),
		.csN      (csN),
		.sioIn    (sioIn),
		.sioOut   (sioOut),
		.sioOe_n  (sioOe_n),
		.readWord (st_reg.snapshot),
		.modeWord (linkWord),
		.modeTgl  (linkTgl)
	);

	// the mode write event crosses as a toggle
	// a level toggle, not a pulse, so no write is lost in the crossing
	pin_sync #(
		.RESET_LEVEL (1'b0)
	) u_tgl_sync (
		.clk      (sys_clk),
		.reset    (reset),
		.pinIn    (linkTgl),
		.levelOut (tglSync)
	);

	// chip select crosses as a level
	// idles high, so leaving reset never looks like a frame start
	pin_sync #(
		.RESET_LEVEL (1'b1)
	) u_cs_sync (
		.clk      (sys_clk),
		.reset    (reset),
		.pinIn    (csN),
		.levelOut (csSync)
	);

	// frame seen from this side
	assign frameBusy = !csSync;

	// upper mode byte plays no part
	assign shutCode = (linkWord[`MODE_SEL_MSB:`MODE_SEL_LSB] == `MODE_SHUT_CODE);

	// a toggle change after arming is one write
	assign modeLoad = st_reg.armed && (tglSync != st_reg.tglSeen);

	// next state of the system side
	always_comb begin
		st_next = st_reg;

		// first cycle after reset adopts the synchronised toggle, which reset forces low,
		// so a stale toggle level of one is taken as a write once it crosses
		if (!st_reg.armed) begin
			st_next.tglSeen = tglSync;
			st_next.armed   = 1'b1;
		end else if (modeLoad) begin
			// the link word has rested for many system clocks by now
			st_next.tglSeen  = tglSync;
			st_next.modeWord = linkWord;
			// a non-listed pattern would be a test mode; treated as its
			// low-byte meaning since the master must avoid it
			if (shutCode) begin
				st_next.mode = MODE_SHUT;
			end else begin
				st_next.mode = MODE_CONT;
			end
		end

		// results are taken only while converting
		// a result offered in shutdown is dropped; the converter is asleep
		if (convDone && st_reg.mode == MODE_CONT) begin
			// one step is 1/TEMP_STEP_DIV degree, two's complement
			st_next.tempValue = convData;
			st_next.firstDone = 1'b1;
		end

		// the read word is frozen while a frame runs, so the link
		// may sample it on its own clock without tearing
		if (!frameBusy) begin
			st_next.snapshot = {st_next.tempValue, st_next.firstDone, 2'b00};
		end
	end

	// one register for all state, synchronous reset
	// the link side is not reset here; select high clears its frame logic
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			st_reg <= RESET_ST;
		end else begin
			st_reg <= st_next;
		end
	end

	// shutdown stops the converter; the serial port stays awake
	assign convRun  = (st_reg.mode == MODE_CONT);
	assign sensMode = st_reg.mode;

	// all checks below run on the system clock
	default clocking cb @(posedge sys_clk);
	endclocking

	default disable iff (reset);

	// a write arrives from the link
	sequence modeArrive;
		st_reg.armed && (tglSync != st_reg.tglSeen);
	endsequence

	// a conversion result is offered while running
	sequence convTaken;
		convDone && st_reg.mode == MODE_CONT;
	endsequence

	// two idle cycles in a row
	sequence idleRun;
		!frameBusy [*2];
	endsequence

	// a write with a zero in the low byte
	sequence contWrite;
		modeArrive ##0 !shutCode;
	endsequence

	// a write of the shutdown code
	sequence shutWrite;
		modeArrive ##0 shutCode;
	endsequence

	// the very first result taken after reset
	sequence firstConv;
		convTaken ##0 !st_reg.firstDone;
	endsequence

	AST_RESET_CONT: assert property (
		$fell(reset) |-> convRun && st_reg.modeWord == `MODE_RESET && !st_reg.firstDone)
		else $error("not continuous after reset");

	AST_SHUT_ENTRY: assert property (
		modeArrive ##0 shutCode |=> sensMode == MODE_SHUT && !convRun)
		else $error("shutdown code did not stop conversion");

	AST_CONT_ENTRY: assert property (
		modeArrive ##0 !shutCode |=> sensMode == MODE_CONT ##1 convRun)
		else $error("zero in low byte did not give continuous mode");

	AST_MODE_STEADY: assert property (
		!modeLoad |=> $stable(st_reg.modeWord))
		else $error("mode word changed without a write");

	AST_FIRST_SET: assert property (
		convTaken |=> st_reg.firstDone)
		else $error("first conversion flag not set");

	AST_FIRST_STICKY: assert property (
		st_reg.firstDone |=> st_reg.firstDone)
		else $error("first conversion flag dropped");

	AST_RESULT_LOAD: assert property (
		convTaken |=> st_reg.tempValue == $past(convData))
		else $error("result not loaded from converter");

	AST_SHUT_HOLD: assert property (
		(convDone && st_reg.mode == MODE_SHUT) |=> $stable(st_reg.tempValue))
		else $error("result changed in shutdown");

	AST_SNAP_LAYOUT: assert property (
		idleRun |-> st_reg.snapshot[15:3] == $past(st_reg.tempValue, 1) ||
			st_reg.snapshot[15:3] == st_reg.tempValue)
		else $error("read word does not carry the result");

	AST_SNAP_FROZEN: assert property (
		frameBusy [*2] |-> $stable(st_reg.snapshot))
		else $error("read word changed during a frame");

	AST_SNAP_LOW: assert property (
		st_reg.snapshot[1:0] == 2'b00 && st_reg.snapshot[2] == st_reg.firstDone ||
			frameBusy || $past(frameBusy))
		else $error("read word low bits wrong");

	// the word and the toggle are taken together in one cycle
	AST_WORD_TAKEN: assert property (
		modeArrive |=> st_reg.modeWord == $past(linkWord) && st_reg.tglSeen == $past(tglSync))
		else $error("mode word not taken on a write");

	// shutdown is kept until the next write
	AST_SHUT_STAYS: assert property (
		shutWrite ##1 !modeLoad |=> sensMode == MODE_SHUT)
		else $error("shutdown left without a write");

	// continuous mode keeps the converter running
	AST_CONT_RUNS: assert property (
		contWrite ##1 !modeLoad |=> convRun)
		else $error("continuous mode left without a write");

	// the first cycle after reset arms the toggle and keeps the reset mode word
	AST_ARM_FIRST: assert property (
		$fell(reset) |=> st_reg.armed && st_reg.modeWord == `MODE_RESET && sensMode == MODE_CONT)
		else $error("stale toggle taken as a write after reset");

	// the result moves only on a taken conversion
	AST_RESULT_STEADY: assert property (
		!(convDone && st_reg.mode == MODE_CONT) |=> $stable(st_reg.tempValue))
		else $error("result changed without a conversion");

	// between frames the whole read word follows the result and flag
	AST_SNAP_WORD: assert property (
		idleRun |-> st_reg.snapshot == {st_reg.tempValue, st_reg.firstDone, 2'b00})
		else $error("idle read word differs from the result");

	// the first conversion raises the flag and it stays raised
	AST_FIRST_ONCE: assert property (
		firstConv |=> st_reg.firstDone ##1 st_reg.firstDone)
		else $error("first conversion flag not kept");
endmodule // temp_sensor_serial_regs

// *** dv/serial_master.sv ***
// bus master model that clocks the sensor's serial link
`timescale 1ns/10ps
module serial_master (
	// link pins
	output logic        sck,
	output logic        csN,
	output logic        sioLine,
	// device side of the split data pin
	input  wire logic   sioOut,
	input  wire logic   sioOe_n,
	// words read in the last frame
	output logic [31:0] rdWords,
	output logic        rdValid
);
	logic mDrv;  // master owns the data line
	logic mBit;  // bit the master drives
	logic flip;  // released line wanders, so no stale bit can be read as good

	// resolved data wire
	always_comb sioLine = !sioOe_n ? sioOut : (mDrv ? mBit : flip);

	// idle: deselected, clock parked low
	initial begin
		sck = 1'b0;
		csN = 1'b1;
		mDrv = 1'b0;
		mBit = 1'b0;
		flip = 1'b0;
		rdWords = '0;
		rdValid = 1'b0;
	end

	// one selection of n clocks; even slots read, odd slots write wr msb first
	task automatic frame(input int n, input logic [31:0] wr);
		int k;
		int b;
		rdWords = '0;
		csN = 1'b0;
		for (k = 0; k < n; k++) begin
			b = 15 - k % 16;
			mDrv = (k / 16) % 2 == 1;
			mBit = wr[b + 16 * (1 - k / 32)];
			#40;
			flip = ~flip;
			// undriven positions record the enable instead of the wandering level
			if ((k / 16) % 2 == 0)
				rdWords[b + 16 * (1 - k / 32)] = (b < 2) ? sioOe_n : sioLine;
			sck = 1'b1;
			#40;
			sck = 1'b0;
		end
		#40;
		csN = 1'b1;
		mDrv = 1'b0;
		rdValid = 1'b1;
		#1;
		rdValid = 1'b0;
	endtask

	// clocks while deselected, which the device must ignore
	task automatic loose(input int n);
		repeat (n) begin
			#40 sck = 1'b1;
			#40 sck = 1'b0;
		end
	endtask
endmodule // serial_master

// *** dv/temp_sensor_serial_regs_test.sv ***
// self-checking bench of the serial temperature sensor register block
`timescale 1ns/10ps
module temp_sensor_serial_regs_test;
	import temp_sensor_serial_pkg::*;
	localparam logic [7:0]  MAKER   = 8'h96;  // arbitrary value
	localparam logic [15:0] ID_WORD = {MAKER, 8'h03};  // low two bits read as released
	logic        sys_clk;
	logic        reset;
	logic        sck;
	logic        csN;
	logic        sioLine;
	logic        sioOut;
	logic        sioOe_n;
	logic [12:0] convData;
	logic        convDone;
	logic        convRun;
	sensMode_t   sensMode;
	logic [31:0] rdWords;
	logic        rdValid;
	logic        modeStb;   // asks the monitor to compare mode outputs
	logic [31:0] rng;       // xorshift state
	logic [31:0] expQ[$];   // expected results, oldest first
	logic [15:0] curTemp;   // expected temperature read word
	logic        shut;      // expected shutdown state
	logic [7:0]  code;
	logic [7:0]  hi;
	int          i;
	int          error_cnt;
	int          checked;

	temp_sensor_serial_regs #(.MAKER_CODE(MAKER)) uut (
		.sys_clk(sys_clk), .reset(reset), .sck(sck), .csN(csN), .sioIn(sioLine), .sioOut(sioOut),
		.sioOe_n(sioOe_n), .convData(convData), .convDone(convDone), .convRun(convRun), .sensMode(sensMode));
	serial_master m (.sck(sck), .csN(csN), .sioLine(sioLine), .sioOut(sioOut), .sioOe_n(sioOe_n),
		.rdWords(rdWords), .rdValid(rdValid));

	// 50 MHz system clock
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	function automatic logic [31:0] rnd();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction

	// takes the oldest note and compares it with what appeared
	task automatic cmp(input logic [31:0] got);
		logic [31:0] exp;
		exp = expQ.pop_front();
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR at %0t: expected %h got %h", $time, exp, got);
		end
	endtask

	// monitor: frames and mode samples
	always @(posedge rdValid) cmp(rdWords);
	always @(posedge modeStb) cmp({30'h0, sensMode, convRun});

	// frame after a gap long enough for the read word to refresh
	task automatic xfer(input int n, input logic [31:0] wr, input logic [31:0] exp);
		repeat (6) @(negedge sys_clk);
		#7;
		expQ.push_back(exp);
		m.frame(n, wr);
		$display("frame of %0d clocks done at %0t", n, $time);
	endtask

	// mode change crosses domains, so allow a bounded settling wait
	task automatic modeIs(input logic [1:0] m2);
		int k;
		expQ.push_back({30'h0, m2});
		for (k = 0; k < 20 && {sensMode, convRun} !== m2; k++)
			@(negedge sys_clk);
		modeStb = 1'b1;
		@(negedge sys_clk);
		modeStb = 1'b0;
	endtask

	// one converter result; kept only while converting
	task automatic convert();
		@(negedge sys_clk);
		convData = 13'(rnd());
		convDone = 1'b1;
		@(negedge sys_clk);
		convDone = 1'b0;
		if (!shut)
			curTemp = {convData, 3'b111};
		repeat (6) @(negedge sys_clk);
	endtask

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// a hang ends the run as a mismatch
	initial begin
		#500000;
		error_cnt++;
		test_done();
	end

	// main sequence
	initial begin
		rng = 32'd64836;
		error_cnt = 0;
		checked = 0;
		reset = 1'b1;
		convData = '0;
		convDone = 1'b0;
		modeStb = 1'b0;
		shut = 1'b0;
		curTemp = 16'hff03;  // reset result, first flag still clear
		repeat (3) @(negedge sys_clk);
		reset = 1'b0;
		modeIs(2'b01);
		xfer(16, 32'h0, {curTemp, 16'h0});
		m.loose(16);
		convert();
		xfer(24, 32'hffff_0000, {curTemp, 16'h0});
		modeIs(2'b01);
		// nine low mode codes 00, 01, 03 and on up to ff, upper byte random
		for (i = 0; i <= 8; i++) begin
			code = 8'((9'h001 << i) - 9'h001);
			hi = 8'(rnd());
			xfer(48, {hi, code, 16'h0}, {curTemp, (code == 8'hff) ? ID_WORD : curTemp});
			shut = (code == 8'hff);
			modeIs(shut ? 2'b10 : 2'b01);
			convert();
		end
		xfer(64, 32'h5a00_00ff, {curTemp, curTemp});
		modeIs(2'b10);
		test_done();
	end
endmodule // temp_sensor_serial_regs_test
